// *** rtl/tcc_pkg.sv ***
// Constants shared by the timer capture/compare register block.
//----------------------------------------------------------------------
// Summary of operation
// - A capture event copies the 16-bit counter value into capture_value.
// - capture_value is driven out as the counter TOP in modes that use it.
// - Each 16-bit register has low byte at base, high byte at base+1.
// - Capture reads are coherent through one shared 8-bit high-byte latch.
// - Compare writes commit both bytes at once through the shared latch.
// - Each compare value is compared with the counter on every timer tick.
// - Capture request needs capture_irq_en bit 5 and global enable.
// - Mask bits 2 and 1 gate compare B and A requests with global enable.
// - Mask bit 0 gates the overflow request with global enable.
// - capture_flag sets on capture, or on reaching TOP in TOP modes.
// - Flags clear on vector execution or by writing one; zero is ignored.
// - Match flags set two clock cycles after a tick where counter equals compare.
// - A forced compare strobe never sets a match flag.
// - overflow_flag sets on counter overflow, timing chosen by mode.
// - A counter write blocks compare matches on the next timer tick.
// - In TOP modes the capture input is disconnected and capture off.
// - capture_edge_sel zero picks falling edge, one picks rising edge.
//----------------------------------------------------------------------
package tcc_pkg;
   localparam logic [7:0] OFS_IRQ_FLAGS = 8'h36;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h6F;
   localparam logic [7:0] OFS_CAPTURE = 8'h86;
   localparam logic [7:0] OFS_COMPARE_A = 8'h88;
   localparam logic [7:0] OFS_COMPARE_B = 8'h8A;
   localparam logic [7:0] OFS_HIGH_BYTE = 8'h01;
   localparam int BIT_CAPTURE = 5;
   localparam int BIT_MATCH_B = 2;
   localparam int BIT_MATCH_A = 1;
   localparam int BIT_OVERFLOW = 0;
   localparam logic [7:0] IRQ_BITS_MASK = 8'h27;
   localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [15:0] RST_VALUE16 = 16'h0000;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CLR_A = 4'h4;
   localparam logic [3:0] MODE_CLR_CAP = 4'hC;
   localparam logic [3:0] MODE_PFC_CAP = 4'h8;
   localparam logic [3:0] MODE_PC_CAP = 4'hA;
   localparam logic [3:0] MODE_FAST_CAP = 4'hE;
   localparam int NUM_CHANNELS = 2;
endpackage : tcc_pkg

// *** rtl/tcc_cmp_if.sv ***
// Signals between the register block and one compare channel.
`timescale 1ns/1ps
`default_nettype none
interface tcc_cmp_if;
   logic [15:0] cmp_value;
   logic [15:0] counter_value;
   logic tick;
   logic block;
   logic force_strobe;
   logic match;
   logic wave;
   modport ctrl (output cmp_value, output counter_value, output tick,
                 output block, output force_strobe, input match,
                 input wave);
   modport chan (input cmp_value, input counter_value, input tick,
                 input block, input force_strobe, output match,
                 output wave);
endinterface : tcc_cmp_if
`default_nettype wire

// *** rtl/tcc_cmp_ch.sv ***
// One output compare channel: equality test, match pulse, wave pulse.
`timescale 1ns/1ps
`default_nettype none
module tcc_cmp_ch (
   input wire logic sys_clk,
   input wire logic rst_n,
   tcc_cmp_if.chan ch
);
   import tcc_pkg::*;

   logic match_q;
   logic wave_q;
   logic hit;

   // Equality counts only on a timer tick that is not blocked
   assign hit = ch.tick && !ch.block &&
                (ch.counter_value == ch.cmp_value);

   // Match pulse lands one cycle after the equal tick
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_q <= 1'b0;
      end else begin
         match_q <= hit;
      end
   end

   // Wave pulse also answers a forced strobe; flags never see it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wave_q <= 1'b0;
      end else begin
         wave_q <= hit || ch.force_strobe;
      end
   end

   assign ch.match = match_q;
   assign ch.wave = wave_q;

   AST_MATCH_NEXT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ch.tick && !ch.block && (ch.counter_value == ch.cmp_value)
      |=> ch.match)
      else $error("compare match pulse missing after equal tick");
   AST_FORCE_NO_MATCH: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      ch.force_strobe && !(ch.tick && !ch.block &&
      (ch.counter_value == ch.cmp_value)) |=> !ch.match && ch.wave)
      else $error("forced strobe produced a match or no wave pulse");
   AST_BLOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ch.block |=> !ch.match)
      else $error("match raised on a blocked tick");
endmodule : tcc_cmp_ch
`default_nettype wire

// *** rtl/tcc_capture_compare.sv ***
// Capture, two compare channels, shared byte latch and interrupt flags.
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_compare (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output var logic [7:0] io_rdata,
   input wire logic timer_tick,
   input wire logic [15:0] counter_value,
   input wire logic counter_wr,
   input wire logic counter_at_top,
   input wire logic counter_ovf,
   input wire logic [3:0] waveform_mode_sel,
   input wire logic capture_edge_sel,
   input wire logic capture_src_cmp,
   input wire logic capture_pin,
   input wire logic comparator_out,
   input wire logic force_match_a,
   input wire logic force_match_b,
   input wire logic global_irq_en,
   input wire logic vec_capture,
   input wire logic vec_match_a,
   input wire logic vec_match_b,
   input wire logic vec_overflow,
   output var logic irq_capture,
   output var logic irq_match_a,
   output var logic irq_match_b,
   output var logic irq_overflow,
   output var logic [15:0] top_value,
   output var logic compare_a_out,
   output var logic compare_b_out
);
   import tcc_pkg::*;

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] mask_q;
   logic [15:0] capture_q;
   logic [15:0] cmp_q [0:NUM_CHANNELS-1];
   logic [7:0] latch_q;
   logic [7:0] rdata_q;
   logic [3:0] irq_q;
   logic cap_prev_q;
   logic block_q;
   logic cap_src;
   logic cap_is_top;
   logic cap_event;
   logic top_event;
   logic ovf_mode_plain;
   logic [NUM_CHANNELS-1:0] match_w;
   logic [NUM_CHANNELS-1:0] wave_w;
   logic [NUM_CHANNELS-1:0] force_w;
   logic wr_flags;
   logic wr_mask;
   logic wr_cap_lo;
   logic wr_cmp_lo [0:NUM_CHANNELS-1];
   logic wr_any_hi;
   logic rd_cap_lo;
   logic rd_cmp_lo [0:NUM_CHANNELS-1];
   logic rd_any_hi;

   //-------------------------------------------------------------------
   // Address decode
   //-------------------------------------------------------------------
   // Data-space addresses only; the I/O alias is the core's remapping
   assign wr_flags = io_wr && (io_addr == OFS_IRQ_FLAGS);
   assign wr_mask = io_wr && (io_addr == OFS_IRQ_MASK);
   assign wr_cap_lo = io_wr && (io_addr == OFS_CAPTURE);
   assign rd_cap_lo = io_rd && (io_addr == OFS_CAPTURE);
   assign wr_any_hi = io_wr &&
      ((io_addr == OFS_CAPTURE + OFS_HIGH_BYTE) ||
       (io_addr == OFS_COMPARE_A + OFS_HIGH_BYTE) ||
       (io_addr == OFS_COMPARE_B + OFS_HIGH_BYTE));
   assign rd_any_hi = io_rd &&
      ((io_addr == OFS_CAPTURE + OFS_HIGH_BYTE) ||
       (io_addr == OFS_COMPARE_A + OFS_HIGH_BYTE) ||
       (io_addr == OFS_COMPARE_B + OFS_HIGH_BYTE));
   assign wr_cmp_lo[0] = io_wr && (io_addr == OFS_COMPARE_A);
   assign wr_cmp_lo[1] = io_wr && (io_addr == OFS_COMPARE_B);
   assign rd_cmp_lo[0] = io_rd && (io_addr == OFS_COMPARE_A);
   assign rd_cmp_lo[1] = io_rd && (io_addr == OFS_COMPARE_B);

   //-------------------------------------------------------------------
   // Capture input
   //-------------------------------------------------------------------
   // Modes that take TOP from capture_value disconnect the input
   assign cap_is_top = (waveform_mode_sel == MODE_PFC_CAP) ||
                       (waveform_mode_sel == MODE_PC_CAP) ||
                       (waveform_mode_sel == MODE_CLR_CAP) ||
                       (waveform_mode_sel == MODE_FAST_CAP);
   assign cap_src = capture_src_cmp ? comparator_out : capture_pin;

   // Previous sample for edge detection; inputs are already synchronous
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_prev_q <= 1'b0;
      end else begin
         cap_prev_q <= cap_src;
      end
   end

   assign cap_event = !cap_is_top &&
      (capture_edge_sel ? (cap_src && !cap_prev_q)
                        : (!cap_src && cap_prev_q));
   assign top_event = cap_is_top && timer_tick && counter_at_top;

   // Capture wins over a CPU write in the same cycle: the event is real
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_q <= RST_VALUE16;
      end else if (cap_event) begin
         capture_q <= counter_value;
      end else if (wr_cap_lo) begin
         capture_q <= {latch_q, io_wdata};
      end
   end

   // TOP for the counter comes straight from the capture register
   assign top_value = capture_q;

   //-------------------------------------------------------------------
   // Compare values and channels
   //-------------------------------------------------------------------
   assign force_w = {force_match_b, force_match_a};

   // Counter writes block the next tick's match on every channel
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         block_q <= 1'b0;
      end else if (counter_wr) begin
         block_q <= 1'b1;
      end else if (timer_tick) begin
         block_q <= 1'b0;
      end
   end

   generate
      for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_ch
         tcc_cmp_if u_if ();

         // Both bytes land together from the latch and the low byte
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               cmp_q[i] <= RST_VALUE16;
            end else if (wr_cmp_lo[i]) begin
               cmp_q[i] <= {latch_q, io_wdata};
            end
         end

         assign u_if.cmp_value = cmp_q[i];
         assign u_if.counter_value = counter_value;
         assign u_if.tick = timer_tick;
         assign u_if.block = block_q;
         assign u_if.force_strobe = force_w[i];
         assign match_w[i] = u_if.match;
         assign wave_w[i] = u_if.wave;

         tcc_cmp_ch u_ch (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ch(u_if.chan)
         );
      end
   endgenerate

   assign compare_a_out = wave_w[0];
   assign compare_b_out = wave_w[1];

   //-------------------------------------------------------------------
   // Shared high-byte latch and read data
   //-------------------------------------------------------------------
   // One latch for all pairs: an interrupt handler touching another
   // pair between the two byte accesses will corrupt the sequence
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= RST_LATCH;
      end else if (wr_any_hi) begin
         latch_q <= io_wdata;
      end else if (rd_cap_lo) begin
         latch_q <= capture_q[15:8];
      end else if (rd_cmp_lo[0]) begin
         latch_q <= cmp_q[0][15:8];
      end else if (rd_cmp_lo[1]) begin
         latch_q <= cmp_q[1][15:8];
      end
   end

   // Read data is registered; unmapped addresses read as zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (io_rd) begin
         if (rd_any_hi) begin
            rdata_q <= latch_q;
         end else begin
            case (io_addr)
               OFS_IRQ_FLAGS: rdata_q <= flags_q;
               OFS_IRQ_MASK: rdata_q <= mask_q;
               OFS_CAPTURE: rdata_q <= capture_q[7:0];
               OFS_COMPARE_A: rdata_q <= cmp_q[0][7:0];
               OFS_COMPARE_B: rdata_q <= cmp_q[1][7:0];
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end

   assign io_rdata = rdata_q;

   //-------------------------------------------------------------------
   // Mask and flags
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= RST_IRQ_MASK;
      end else if (wr_mask) begin
         mask_q <= io_wdata & IRQ_BITS_MASK;
      end
   end

   // The overflow input is already timed by the counter for PWM modes
   assign ovf_mode_plain = (waveform_mode_sel == MODE_NORMAL) ||
                           (waveform_mode_sel == MODE_CLR_A) ||
                           (waveform_mode_sel == MODE_CLR_CAP);

   // Clears first, sets last, so a new event is never lost
   always_comb begin
      flags_d = flags_q;
      if (wr_flags) begin
         flags_d = flags_q & ~io_wdata;
      end
      if (vec_capture) begin
         flags_d[BIT_CAPTURE] = 1'b0;
      end
      if (vec_match_a) begin
         flags_d[BIT_MATCH_A] = 1'b0;
      end
      if (vec_match_b) begin
         flags_d[BIT_MATCH_B] = 1'b0;
      end
      if (vec_overflow) begin
         flags_d[BIT_OVERFLOW] = 1'b0;
      end
      if (cap_event || top_event) begin
         flags_d[BIT_CAPTURE] = 1'b1;
      end
      if (match_w[0]) begin
         flags_d[BIT_MATCH_A] = 1'b1;
      end
      if (match_w[1]) begin
         flags_d[BIT_MATCH_B] = 1'b1;
      end
      if (counter_ovf && (timer_tick || !ovf_mode_plain)) begin
         flags_d[BIT_OVERFLOW] = 1'b1;
      end
      flags_d = flags_d & IRQ_BITS_MASK;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= RST_IRQ_FLAGS;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Requests need flag, enable and the core's global enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 4'h0;
      end else begin
         irq_q[3] <= flags_q[BIT_CAPTURE] && mask_q[BIT_CAPTURE] &&
                     global_irq_en;
         irq_q[2] <= flags_q[BIT_MATCH_B] && mask_q[BIT_MATCH_B] &&
                     global_irq_en;
         irq_q[1] <= flags_q[BIT_MATCH_A] && mask_q[BIT_MATCH_A] &&
                     global_irq_en;
         irq_q[0] <= flags_q[BIT_OVERFLOW] && mask_q[BIT_OVERFLOW] &&
                     global_irq_en;
      end
   end

   assign irq_capture = irq_q[3];
   assign irq_match_b = irq_q[2];
   assign irq_match_a = irq_q[1];
   assign irq_overflow = irq_q[0];

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   sequence s_low_read_cap;
      io_rd && (io_addr == OFS_CAPTURE) && !cap_event;
   endsequence
   sequence s_high_read_cap;
      io_rd && (io_addr == OFS_CAPTURE + OFS_HIGH_BYTE) && !io_wr;
   endsequence
   sequence s_high_write_a;
      io_wr && (io_addr == OFS_COMPARE_A + OFS_HIGH_BYTE);
   endsequence
   sequence s_low_write_a;
      io_wr && (io_addr == OFS_COMPARE_A) && !io_rd;
   endsequence

   AST_CAPTURE_COPY: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      cap_event |=> capture_q == $past(counter_value))
      else $error("capture did not copy the counter value");
   AST_CAPTURE_OFF_IN_TOP: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      cap_is_top && !wr_cap_lo |=> $stable(capture_q))
      else $error("capture register moved while used as TOP");
   AST_RISING_EDGE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      capture_edge_sel && !cap_is_top && !cap_src ##1
      capture_edge_sel && !cap_is_top && cap_src
      |=> flags_q[BIT_CAPTURE])
      else $error("rising capture edge did not set capture flag");
   AST_COHERENT_READ: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      s_low_read_cap ##1 (!io_rd && !io_wr) ##1 s_high_read_cap
      |=> io_rdata == $past(capture_q[15:8], 3))
      else $error("high byte read not coherent with low byte read");
   AST_ATOMIC_WRITE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      s_high_write_a ##1 (!io_wr && !io_rd) ##1 s_low_write_a
      |=> cmp_q[0] == {$past(io_wdata, 3), $past(io_wdata)})
      else $error("compare A did not commit both bytes together");
   AST_HIGH_WRITE_HOLDS: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      s_high_write_a |=> $stable(cmp_q[0]))
      else $error("high byte write changed compare A early");
   AST_CAPTURE_IRQ: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      flags_q[BIT_CAPTURE] && mask_q[BIT_CAPTURE] && !global_irq_en
      |=> !irq_capture)
      else $error("capture request raised with global enable off");
   AST_MATCH_IRQ: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      flags_q[BIT_MATCH_B] && mask_q[BIT_MATCH_B] && global_irq_en
      |=> irq_match_b)
      else $error("compare B request missing");
   AST_OVF_IRQ: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      irq_overflow |-> $past(flags_q[BIT_OVERFLOW] &&
      mask_q[BIT_OVERFLOW]))
      else $error("overflow request without flag and enable");
   AST_W1C: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      wr_flags && io_wdata[BIT_OVERFLOW] && !counter_ovf
      |=> !flags_q[BIT_OVERFLOW])
      else $error("writing one did not clear the overflow flag");
   AST_SET_WINS: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      vec_match_a && match_w[0] |=> flags_q[BIT_MATCH_A])
      else $error("match A event lost against vector clear");
   AST_MATCH_FLAG: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      timer_tick && !block_q && (counter_value == cmp_q[0])
      |-> ##2 flags_q[BIT_MATCH_A])
      else $error("match A flag not set two cycles after equality");
   AST_OVF_FLAG: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      counter_ovf && timer_tick |=> flags_q[BIT_OVERFLOW])
      else $error("overflow flag not set on overflow");
   AST_TOP_FLAG: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      top_event |=> flags_q[BIT_CAPTURE])
      else $error("capture flag not set on reaching TOP");
   AST_BLOCK_ARMED: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      counter_wr |=> block_q)
      else $error("counter write did not arm the match block");
endmodule : tcc_capture_compare
`default_nettype wire

// *** verif/tcc_cpu_model.sv ***
// CPU core model driving the timer block's byte-wide register port.
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
   input wire logic sys_clk,
   output logic [7:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   // Idle bus at time zero, no strobe before the bench asks
   initial begin
      io_addr = 8'hFF;
      io_wr = 1'h0;
      io_rd = 1'h0;
      io_wdata = 8'hFF;
   end

   // Store: data-space address only, never the short I/O alias
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'h1;
      @(negedge sys_clk);
      io_wr = 1'h0;
      // Released lines show the inverse so stale values never pass
      io_addr = ~a;
      io_wdata = ~d;
   endtask : wr

   // Load: data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      io_addr = a;
      io_rd = 1'h1;
      @(negedge sys_clk);
      io_rd = 1'h0;
      io_addr = ~a;
      d = io_rdata;
   endtask : rd
endmodule : tcc_cpu_model
`default_nettype wire

// *** verif/tcc_capture_compare_tb.sv ***
// Self-checking bench for the timer capture/compare register block.
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_compare_tb;
   import tcc_pkg::*;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] io_addr, io_wdata, io_rdata, rv;
   logic io_wr, io_rd, irq_capture, irq_match_a, irq_match_b, irq_overflow;
   logic compare_a_out, compare_b_out;
   logic [15:0] top_value;
   logic [15:0] counter_value = 16'h0000;
   logic [3:0] waveform_mode_sel = 4'h0;
   logic capture_edge_sel = 1'h0, capture_src_cmp = 1'h0;
   logic global_irq_en = 1'h1;
   // Inputs: pin in bit 0, comparator in bit 1
   logic [1:0] cin = 2'h3;
   // Strobes: tick,cwr,top,ovf,fa,fb,vcap,va,vb,vovf from bit 0
   logic [9:0] st = 10'h000;
   int err_total = 0, tests_run = 0, pa = 0, pb = 0;
   logic [7:0] ofs [9] = '{8'h36, 8'h6F, 8'h86, 8'h87, 8'h88, 8'h89,
                           8'h8A, 8'h8B, 8'h50};

   always #2.5 sys_clk = ~sys_clk;

   // Count output pulses so the exact width is checked, not one sample
   always @(posedge sys_clk) begin
      if (compare_a_out === 1'h1) pa++;
      if (compare_b_out === 1'h1) pb++;
   end

   tcc_capture_compare i_tcc_capture_compare (.sys_clk, .rst_n, .io_addr,
      .io_wr, .io_rd, .io_wdata, .io_rdata, .timer_tick(st[0]),
      .counter_value, .counter_wr(st[1]), .counter_at_top(st[2]),
      .counter_ovf(st[3]), .waveform_mode_sel, .capture_edge_sel,
      .capture_src_cmp, .capture_pin(cin[0]), .comparator_out(cin[1]),
      .force_match_a(st[4]), .force_match_b(st[5]), .global_irq_en,
      .vec_capture(st[6]), .vec_match_a(st[7]), .vec_match_b(st[8]),
      .vec_overflow(st[9]), .irq_capture, .irq_match_a, .irq_match_b,
      .irq_overflow, .top_value, .compare_a_out, .compare_b_out);

   tcc_cpu_model i_tcc_cpu_model (.sys_clk, .io_addr, .io_wr, .io_rd,
      .io_wdata, .io_rdata);

   //----------------------------------------------------------------
   // Helpers
   //----------------------------------------------------------------
   task automatic check(input string w, input logic [15:0] s,
                        input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", w, e, s);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : step

   // Strobes stand exactly one cycle
   task automatic pulse(input logic [9:0] m);
      @(negedge sys_clk);
      st = m;
      @(negedge sys_clk);
      st = 10'h000;
   endtask : pulse

   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      i_tcc_cpu_model.rd(a, rv);
      check($sformatf("reg %h", a), rv, e);
   endtask : rdx

   // Low byte first so the latch holds the matching high byte
   task automatic rd16x(input logic [7:0] a, input logic [15:0] e);
      rdx(a, e[7:0]);
      rdx(a + OFS_HIGH_BYTE, e[15:8]);
   endtask : rd16x

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_tcc_cpu_model.wr(a, d);
   endtask : wr

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // Watchdog: a hang counts as a mismatch
   initial begin
      #20000;
      err_total++;
      close_out();
   end

   //----------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) rst_n = 1'h1;
      foreach (ofs[i]) rdx(ofs[i], 8'h00);
      wr(8'h50, 8'hFF);
      rdx(8'h50, 8'h00);
      wr(OFS_IRQ_MASK, 8'hFF);
      rdx(OFS_IRQ_MASK, IRQ_BITS_MASK);
      wr(OFS_IRQ_FLAGS, 8'hFF);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      // High byte goes to the latch, low byte commits the pair
      wr(OFS_COMPARE_A + OFS_HIGH_BYTE, 8'h12);
      wr(OFS_COMPARE_A, 8'h34);
      wr(OFS_COMPARE_B + OFS_HIGH_BYTE, 8'h56);
      wr(OFS_COMPARE_B, 8'h78);
      rd16x(OFS_COMPARE_A, 16'h1234);
      rd16x(OFS_COMPARE_B, 16'h5678);
      wr(OFS_COMPARE_A + OFS_HIGH_BYTE, 8'hAA);
      rd16x(OFS_COMPARE_A, 16'h1234);
      // Forced strobes pulse the outputs but leave the flags alone
      pulse(10'h030);
      step(3);
      check("force a", pa, 1);
      check("force b", pb, 1);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      // Equality only counts on a timer tick
      counter_value = 16'h1234;
      pulse(10'h001);
      step(3);
      check("match a", pa, 2);
      rdx(OFS_IRQ_FLAGS, 8'h02);
      check("irq a", irq_match_a, 1);
      counter_value = 16'h5678;
      pulse(10'h001);
      step(3);
      check("match b", pb, 2);
      rdx(OFS_IRQ_FLAGS, 8'h06);
      check("irq b", irq_match_b, 1);
      wr(OFS_IRQ_FLAGS, 8'h02);
      rdx(OFS_IRQ_FLAGS, 8'h04);
      check("irq a off", irq_match_a, 0);
      pulse(10'h100);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      // A counter write hides the next tick's match only
      counter_value = 16'h1234;
      pulse(10'h002);
      pulse(10'h001);
      step(3);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      pulse(10'h001);
      step(3);
      rdx(OFS_IRQ_FLAGS, 8'h02);
      wr(OFS_IRQ_FLAGS, 8'h02);
      // A vector clear meeting a new match pulse loses to the set
      step(1);
      st = 10'h001;
      step(1);
      st = 10'h080;
      step(1);
      st = 10'h000;
      step(3);
      rdx(OFS_IRQ_FLAGS, 8'h02);
      wr(OFS_IRQ_FLAGS, 8'h02);
      // Each edge sense from each source; the return edge is ignored
      for (int i = 0; i < 4; i++) begin
         capture_edge_sel = i[0];
         capture_src_cmp = i[1];
         cin = {2{~i[0]}};
         step(2);
         wr(OFS_IRQ_FLAGS, 8'h20);
         counter_value = 16'h1100 + 16'(i);
         cin[i[1]] = i[0];
         step(2);
         rdx(OFS_IRQ_FLAGS, 8'h20);
         rd16x(OFS_CAPTURE, 16'h1100 + 16'(i));
         check("irq cap", irq_capture, 1);
         counter_value = 16'hFFFF;
         cin[i[1]] = ~i[0];
         step(2);
         rd16x(OFS_CAPTURE, 16'h1100 + 16'(i));
      end
      // Capture register as TOP: comparator input ignored, flag follows TOP
      wr(OFS_IRQ_FLAGS, 8'h20);
      waveform_mode_sel = MODE_CLR_CAP;
      step(2);
      cin[1] = 1'h1;
      step(2);
      rd16x(OFS_CAPTURE, 16'h1103);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      check("top", top_value, 16'h1103);
      pulse(10'h005);
      step(2);
      rdx(OFS_IRQ_FLAGS, 8'h20);
      global_irq_en = 1'h0;
      step(2);
      check("irq cap off", irq_capture, 0);
      pulse(10'h040);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      // Overflow: tick-qualified in normal and clear modes, pre-timed in PWM modes
      waveform_mode_sel = MODE_NORMAL;
      global_irq_en = 1'h0;
      pulse(10'h008);
      step(2);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      pulse(10'h009);
      step(2);
      rdx(OFS_IRQ_FLAGS, 8'h01);
      check("irq ovf off", irq_overflow, 0);
      global_irq_en = 1'h1;
      step(3);
      check("irq ovf", irq_overflow, 1);
      pulse(10'h200);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      waveform_mode_sel = MODE_FAST_CAP;
      pulse(10'h008);
      step(2);
      rdx(OFS_IRQ_FLAGS, 8'h01);
      // Clear-on-match with compare A as TOP still wants a tick
      wr(OFS_IRQ_FLAGS, 8'h01);
      waveform_mode_sel = MODE_CLR_A;
      pulse(10'h008);
      rdx(OFS_IRQ_FLAGS, 8'h00);
      // MODE_PFC_CAP and MODE_PC_CAP also ignore the input
      for (int m = 0; m < 2; m++) begin
         waveform_mode_sel = m[0] ? MODE_PC_CAP : MODE_PFC_CAP;
         cin[1] = 1'h0;
         step(2);
         cin[1] = 1'h1;
         step(2);
         rdx(OFS_IRQ_FLAGS, 8'h00);
      end
      close_out();
   end
endmodule : tcc_capture_compare_tb
`default_nettype wire
